/* File: logic/clamp_sample_pkg.sv */
// What this block does
// - Clamp enable clear keeps clamp switch open.
// - Normal mode, source 0: clamp follows reset pin.
// - Normal mode, source 1: clamp needs both pins.
// - Compat mode without auto-cycle: clamp is generated strobe AND reset pin.
// - Compat auto-cycle: source select gates generated strobe.
// - Normal mode: video sample on video pin fall.
// - Normal mode double sampling: reset sample on reset pin fall.
// - No double sampling: reference sampled with video.
// - Compat: video sample first edge after pin low.
// - Compat double sampling: reset sample position field.
// - Each channel has own offset and gain codes.
// - Line mode: cycle or select coefficient set.
// - Black level 10 gives zero code ffff.
// - Black level 11 gives zero code 0000.
// - Black level 00 or 01 gives 7fff.
// - Converter word passes optional inversion stage.
// - Reference from DAC code or external pin.
// - Invert bit outputs ffff minus word.
// - Colour select 00 red, 01 green, 10 blue.
// - Auto-cycle reset write returns cycle to red; a reset pulse in the same cycle steps it on to green.
`default_nettype none
package clamp_sample_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DAC = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [5:0] AUTO_CYCLE_ENABLE_RESET_INDEX = 6'h05;
  localparam logic [7:0] ADDR_AUTO_CYCLE_ENABLE_RESET = {AUTO_CYCLE_ENABLE_RESET_INDEX, 2'b00};
  localparam logic [7:0] ADDR_COEF_RED = 8'h20;
  localparam logic [7:0] ADDR_COEF_GREEN = 8'h24;
  localparam logic [7:0] ADDR_COEF_BLUE = 8'h28;
  localparam int OFFSET_LSB = 0;
  localparam int GAIN_LSB = 16;
  localparam logic [13:0] CTRL_RESET = 14'h0021;
  localparam logic [7:0] OFFSET_RESET = 8'h80;
  localparam logic [8:0] GAIN_RESET = 9'h000;
  localparam logic [3:0] DAC_RESET = 4'h0;
  localparam logic [2:0] PHASE_IDLE = 3'h7;
  localparam logic [15:0] CODE_FULL = 16'hffff;
  localparam logic [15:0] CODE_ZERO = 16'h0000;
  localparam logic [15:0] CODE_MID = 16'h7fff;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {COL_RED, COL_GREEN, COL_BLUE} colour_e;

  typedef struct packed {
    logic [1:0] colour_coef_select;
    logic [1:0] reset_sample_position;
    logic [1:0] black_level_select;
    logic output_invert_bit;
    logic external_clamp_ref_bit;
    logic double_sampling_enable;
    logic auto_cycle_enable;
    logic single_input_colour_mode;
    logic clamp_source_select;
    logic compat_timing_mode;
    logic clamp_enable_bit;
  } ctrl_s;

  typedef struct packed {
    logic [8:0] gain_code;
    logic [7:0] offset_code;
  } coef_s;

  typedef struct packed {
    logic video_sample_point;
    logic reset_sample_point;
    logic ref_sample;
    logic rs_gen;
    logic reset_rise;
  } strobe_s;
endpackage
`default_nettype wire

/* File: logic/sample_timing.sv */
`default_nettype none
module sample_timing
  import clamp_sample_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic video_sample_pin,
  input wire logic reset_sample_pin,
  input wire logic compat_timing_mode,
  input wire logic double_sampling_enable,
  input wire logic [1:0] reset_sample_position,
  output strobe_s strobes
);
  logic video_prev;
  logic reset_prev;
  logic [2:0] phase;
  logic video_fall;
  logic reset_fall;

  assign video_fall = video_prev & ~video_sample_pin;
  assign reset_fall = reset_prev & ~reset_sample_pin;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      video_prev <= 1'b0;
      reset_prev <= 1'b0;
    end else begin
      video_prev <= video_sample_pin;
      reset_prev <= reset_sample_pin;
    end
  end

  // Counts master clock cycles since the last compatibility video sample, holding at PHASE_IDLE (7).
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase <= PHASE_IDLE;
    end else if (compat_timing_mode && video_fall) begin
      phase <= 3'h0;
    end else if (phase != PHASE_IDLE) begin
      phase <= phase + 3'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strobes <= '0;
    end else begin
      // Both modes sample video on the edge that first sees the pin low.
      strobes.video_sample_point <= video_fall;
      strobes.reset_sample_point <= double_sampling_enable &&
        (compat_timing_mode ? (phase == {1'b0, reset_sample_position})
                            : reset_fall);
      strobes.ref_sample <= video_fall && !double_sampling_enable;
      strobes.rs_gen <= compat_timing_mode && double_sampling_enable &&
        (phase == {1'b0, reset_sample_position});
      strobes.reset_rise <= reset_sample_pin & ~reset_prev;
    end
  end
endmodule
`default_nettype wire

/* File: logic/clamp_sample_control.sv */
`default_nettype none
module clamp_sample_control
  import clamp_sample_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic video_sample_pin,
  input wire logic reset_sample_pin,
  input wire logic [15:0] adc_word,
  input wire logic adc_valid,
  output logic reset_level_clamp,
  output strobe_s strobes,
  output logic ref_from_external,
  output logic [3:0] clamp_dac_code,
  output coef_s red_coef,
  output coef_s green_coef,
  output coef_s blue_coef,
  output logic [15:0] zero_level_code,
  output logic [15:0] data_out,
  output logic data_valid
);
  ctrl_s ctrl;
  coef_s coef [0:2];
  colour_e cycle;
  logic [7:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_held;
  logic do_write;
  logic wr_mapped;
  logic auto_cycle_enable_reset_wr;
  logic [31:0] rd_value;
  logic rd_mapped;
  logic line_cycling;

  // ==========================================================
  // Helpers
  // ==========================================================
  // Merges new write data into an old word under byte enables.
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = data[8*i +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [31:0] coef_word(input coef_s c);
    logic [31:0] w;
    w = '0;
    w[OFFSET_LSB +: 8] = c.offset_code;
    w[GAIN_LSB +: 9] = c.gain_code;
    return w;
  endfunction

  function automatic coef_s word_coef(input logic [31:0] w);
    coef_s c;
    c.offset_code = w[OFFSET_LSB +: 8];
    c.gain_code = w[GAIN_LSB +: 9];
    return c;
  endfunction

  function automatic logic is_coef(input logic [7:0] a);
    return a == ADDR_COEF_RED || a == ADDR_COEF_GREEN ||
           a == ADDR_COEF_BLUE;
  endfunction

  // ==========================================================
  // Register bus
  // ==========================================================
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign wr_mapped = aw_addr == ADDR_CTRL || aw_addr == ADDR_DAC ||
                     aw_addr == ADDR_AUTO_CYCLE_ENABLE_RESET || is_coef(aw_addr);
  assign auto_cycle_enable_reset_wr = do_write && aw_addr == ADDR_AUTO_CYCLE_ENABLE_RESET;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[7:2], 2'b00};
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= CTRL_RESET;
      clamp_dac_code <= DAC_RESET;
    end else if (do_write && aw_addr == ADDR_CTRL) begin
      ctrl <= 14'(merge({18'h0, ctrl}, w_data, w_strb));
    end else if (do_write && aw_addr == ADDR_DAC) begin
      clamp_dac_code <= w_strb[0] ? w_data[3:0] : clamp_dac_code;
    end
  end

  // Every channel keeps its own offset and gain pair.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 3; i++) begin
        coef[i] <= {GAIN_RESET, OFFSET_RESET};
      end
    end else if (do_write && is_coef(aw_addr)) begin
      coef[aw_addr[3:2]] <= word_coef(merge(coef_word(coef[aw_addr[3:2]]),
                                            w_data, w_strb));
    end
  end

  always_comb begin
    rd_value = 32'h0;
    rd_mapped = 1'b1;
    case (s_axi_araddr[7:2])
      ADDR_CTRL[7:2]: rd_value = {18'h0, ctrl};
      ADDR_DAC[7:2]: rd_value = {28'h0, clamp_dac_code};
      ADDR_STATUS[7:2]: rd_value = {28'h0, cycle, reset_level_clamp,
                                    data_valid};
      ADDR_COEF_RED[7:2]: rd_value = coef_word(coef[0]);
      ADDR_COEF_GREEN[7:2]: rd_value = coef_word(coef[1]);
      ADDR_COEF_BLUE[7:2]: rd_value = coef_word(coef[2]);
      ADDR_AUTO_CYCLE_ENABLE_RESET[7:2]: rd_value = 32'h0;
      default: rd_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_value;
        s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Sampling strobes and clamp switch
  // ==========================================================
  sample_timing timing (
    .aclk(aclk),
    .aresetn(aresetn),
    .video_sample_pin(video_sample_pin),
    .reset_sample_pin(reset_sample_pin),
    .compat_timing_mode(ctrl.compat_timing_mode),
    .double_sampling_enable(ctrl.double_sampling_enable),
    .reset_sample_position(ctrl.reset_sample_position),
    .strobes(strobes)
  );

  assign line_cycling = ctrl.single_input_colour_mode &&
                        ctrl.auto_cycle_enable;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reset_level_clamp <= 1'b0;
    end else if (!ctrl.clamp_enable_bit) begin
      reset_level_clamp <= 1'b0;
    end else if (ctrl.compat_timing_mode && line_cycling) begin
      // The reset pin only steps the colours here.
      reset_level_clamp <= ctrl.clamp_source_select &&
                           strobes.rs_gen;
    end else if (ctrl.compat_timing_mode) begin
      reset_level_clamp <= strobes.rs_gen && reset_sample_pin;
    end else if (!ctrl.clamp_source_select) begin
      reset_level_clamp <= reset_sample_pin;
    end else begin
      reset_level_clamp <= reset_sample_pin &&
                           video_sample_pin;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_from_external <= 1'b0;
    end else begin
      ref_from_external <= ctrl.external_clamp_ref_bit;
    end
  end

  // ==========================================================
  // Colour coefficient selection
  // ==========================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cycle <= COL_RED;
    end else if (line_cycling && strobes.reset_rise) begin
      // A pulse in the same cycle as a reset write steps from red.
      case (auto_cycle_enable_reset_wr ? COL_RED : cycle)
        COL_RED: cycle <= COL_GREEN;
        COL_GREEN: cycle <= COL_BLUE;
        default: cycle <= COL_RED;
      endcase
    end else if (auto_cycle_enable_reset_wr) begin
      cycle <= COL_RED;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      red_coef <= {GAIN_RESET, OFFSET_RESET};
      green_coef <= {GAIN_RESET, OFFSET_RESET};
      blue_coef <= {GAIN_RESET, OFFSET_RESET};
    end else begin
      green_coef <= coef[1];
      blue_coef <= coef[2];
      if (!ctrl.single_input_colour_mode) begin
        red_coef <= coef[0];
      end else if (ctrl.auto_cycle_enable) begin
        red_coef <= coef[cycle];
      end else begin
        case (ctrl.colour_coef_select)
          2'b01: red_coef <= coef[1];
          2'b10: red_coef <= coef[2];
          default: red_coef <= coef[0];
        endcase
      end
    end
  end

  // ==========================================================
  // Output word path
  // ==========================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      zero_level_code <= CODE_MID;
    end else begin
      case (ctrl.black_level_select)
        2'b10: zero_level_code <= CODE_FULL;
        2'b11: zero_level_code <= CODE_ZERO;
        default: zero_level_code <= CODE_MID;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_out <= 16'h0000;
      data_valid <= 1'b0;
    end else begin
      data_valid <= adc_valid;
      if (adc_valid) begin
        data_out <= ctrl.output_invert_bit ? CODE_FULL - adc_word
                                           : adc_word;
      end
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  a_clamp_disabled: assert property (@(posedge aclk)
    disable iff (!aresetn) !$past(ctrl.clamp_enable_bit) |->
    !reset_level_clamp) else $error("clamp closed while disabled");
  a_clamp_direct: assert property (@(posedge aclk)
    disable iff (!aresetn) $past(ctrl.clamp_enable_bit &&
    !ctrl.compat_timing_mode && !ctrl.clamp_source_select)
    |-> reset_level_clamp == $past(reset_sample_pin))
    else $error("clamp does not follow reset pin");
  a_clamp_both_pins: assert property (@(posedge aclk)
    disable iff (!aresetn) $past(ctrl.clamp_enable_bit &&
    !ctrl.compat_timing_mode && ctrl.clamp_source_select)
    |-> reset_level_clamp == $past(reset_sample_pin && video_sample_pin))
    else $error("clamp not gated by both pins");
  a_clamp_compat: assert property (@(posedge aclk)
    disable iff (!aresetn) reset_level_clamp &&
    $past(ctrl.compat_timing_mode) |-> $past(strobes.rs_gen))
    else $error("compat clamp without generated strobe");
  a_clamp_cycling: assert property (@(posedge aclk)
    disable iff (!aresetn) $past(ctrl.compat_timing_mode && line_cycling &&
    !ctrl.clamp_source_select) |-> !reset_level_clamp)
    else $error("auto-cycle clamp not disabled");
  a_video_fall: assert property (@(posedge aclk)
    disable iff (!aresetn) $fell(video_sample_pin) |=>
    strobes.video_sample_point) else $error("video sample missed");
  a_ref_sample: assert property (@(posedge aclk)
    disable iff (!aresetn) strobes.ref_sample ==
    (strobes.video_sample_point && !$past(ctrl.double_sampling_enable)))
    else $error("reference sample wrong");
  a_zero_code: assert property (@(posedge aclk)
    disable iff (!aresetn) $past(ctrl.black_level_select) == 2'b11
    |-> zero_level_code == CODE_ZERO)
    else $error("black level zero code wrong");
  a_invert_word: assert property (@(posedge aclk)
    disable iff (!aresetn) $past(adc_valid && ctrl.output_invert_bit)
    |-> data_out == CODE_FULL - $past(adc_word))
    else $error("inverted word wrong");
  a_cycle_reset: assert property (@(posedge aclk)
    disable iff (!aresetn) auto_cycle_enable_reset_wr && !strobes.reset_rise |=>
    cycle == COL_RED) else $error("auto-cycle reset ignored");
endmodule
`default_nettype wire

/* File: testbench/pin_driver.sv */
`default_nettype none
// ==========================================================
// Timing controller model: drives the two sample strobe pins.
module pin_driver (
  input wire logic aclk,
  output logic video_sample_pin,
  output logic reset_sample_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    video_sample_pin = 1'b0;
    reset_sample_pin = 1'b0;
  end
  task automatic set_levels(input logic v, input logic r);
    @(posedge aclk);
    video_sample_pin <= v;
    reset_sample_pin <= r;
  endtask
  // A one-clock pulse; the sample follows its falling edge.
  task automatic pulse_video();
    @(posedge aclk);
    video_sample_pin <= 1'b1;
    @(posedge aclk);
    video_sample_pin <= 1'b0;
  endtask
  task automatic pulse_reset();
    @(posedge aclk);
    reset_sample_pin <= 1'b1;
    @(posedge aclk);
    reset_sample_pin <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: testbench/clamp_and_sample_control_tb_top.sv */
`default_nettype none
module clamp_and_sample_control_tb_top import clamp_sample_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, vpin, rpin, clamp, ref_ext, data_valid;
  logic aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, adc_valid = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] bresp, rresp;
  logic [3:0] dac_code;
  logic [15:0] adc_word = 16'h0, zero_code, data_out;
  strobe_s strobes;
  coef_s red_c, green_c, blue_c;
  int errors = 0, checks = 0, seed, vs_n = 0, rs_n = 0, ref_n = 0, cl_n = 0;
  int ctrl_m;
  int cyc = 0, vs_t = 0, rs_t = 0, gen_t = 0;
  int coef_m[3];
  int q[$];
  // ==========================================================
  // Clock, partner and design.
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  pin_driver pins_u (.aclk(aclk), .video_sample_pin(vpin),
    .reset_sample_pin(rpin));
  clamp_sample_control dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .video_sample_pin(vpin),
    .reset_sample_pin(rpin), .adc_word(adc_word), .adc_valid(adc_valid),
    .reset_level_clamp(clamp), .strobes(strobes),
    .ref_from_external(ref_ext), .clamp_dac_code(dac_code),
    .red_coef(red_c), .green_coef(green_c), .blue_coef(blue_c),
    .zero_level_code(zero_code), .data_out(data_out),
    .data_valid(data_valid));
  always @(posedge aclk) begin
    vs_n <= vs_n + strobes.video_sample_point;
    rs_n <= rs_n + strobes.reset_sample_point;
    ref_n <= ref_n + strobes.ref_sample;
    cl_n <= cl_n + clamp;
    cyc <= cyc + 1;
    if (strobes.video_sample_point) vs_t <= cyc;
    if (strobes.reset_sample_point) rs_t <= cyc;
    if (strobes.rs_gen) gen_t <= cyc;
  end
  // ==========================================================
  // Shared tasks.
  task automatic end_of_test();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    end_of_test();
  end
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input int d,
                    output logic [1:0] resp);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] resp);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  task automatic setc(input int c);
    logic [1:0] r;
    wr(ADDR_CTRL, c, r);
    ctrl_m = c;
    repeat (2) @(posedge aclk);
  endtask
  function automatic logic [31:0] coef_of(input int i);
    logic [31:0] c;
    c = coef_m[i];
    return {15'h0, c[24:16], c[7:0]};
  endfunction
  // Counts strobes and clamp cycles over one pixel.
  task automatic pixel(input int vs_e, rs_e, ref_e, cl_e, input bit pr);
    int v0, r0, f0, c0;
    v0 = vs_n;
    r0 = rs_n;
    f0 = ref_n;
    c0 = cl_n;
    pins_u.pulse_video();
    if (pr) pins_u.pulse_reset();
    repeat (12) @(posedge aclk);
    check("video samples", vs_n - v0, vs_e);
    check("reset samples", rs_n - r0, rs_e);
    check("ref samples", ref_n - f0, ref_e);
    check("clamp cycles", cl_n - c0, cl_e);
  endtask
  // ==========================================================
  // Main sequence.
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [15:0] w;
    int e;
    seed = 32'h3ff417f0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_CTRL, d, r);
    check("ctrl reset", d, 32'h21);
    check("zero reset", zero_code, 16'h7fff);
    check("red reset", red_c, {GAIN_RESET, OFFSET_RESET});
    rd(8'h3c, d, r);
    check("unmapped read", r, 2'b10);
    wr(8'h3c, 32'h5, r);
    check("unmapped write", r, 2'b10);
    wr(ADDR_DAC, 32'ha, r);
    rd(ADDR_DAC, d, r);
    check("dac read", d, 32'ha);
    check("dac code", dac_code, 4'ha);
    for (int i = 0; i < 8; i++) begin
      setc(32'h21 | (i >> 1) << 8 | (i & 1) << 7 | (i & 1) << 6);
      e = (i >> 1) == 2 ? 16'hffff : (i >> 1) == 3 ? 0 : 16'h7fff;
      check("zero code", zero_code, e);
      check("ref ext", ref_ext, i & 1);
      w = 16'($random(seed));
      @(posedge aclk);
      adc_word <= w;
      adc_valid <= 1'b1;
      @(posedge aclk);
      adc_valid <= 1'b0;
      @(posedge aclk);
      check("data valid", data_valid, 1'b1);
      e = (ctrl_m >> 7 & 1) ? 65535 - w : w;
      check("data out", data_out, e);
    end
    for (int i = 0; i < 16; i++) begin
      setc((i & 1) | (i & 2) << 1);
      pins_u.set_levels(i[2], i[3]);
      repeat (3) @(posedge aclk);
      e = i[0] & (i[1] ? i[2] & i[3] : i[3]);
      check("clamp level", clamp, e);
    end
    pins_u.set_levels(1'b0, 1'b0);
    setc(32'h21);
    pixel(1, 1, 0, 1, 1);
    setc(32'h01);
    pixel(1, 0, 1, 1, 1);
    for (int p = 0; p < 4; p++) begin
      setc(32'h23 | p << 10);
      pins_u.set_levels(1'b0, 1'b1);
      pixel(1, 1, 0, 1, 0);
      check("reset position", rs_t - vs_t, p + 1);
      check("strobe position", gen_t - vs_t, p + 1);
    end
    pins_u.set_levels(1'b0, 1'b0);
    pixel(1, 1, 0, 0, 0);
    setc(32'h03);
    pixel(1, 0, 1, 0, 0);
    pins_u.set_levels(1'b0, 1'b1);
    setc(32'h3b);
    pixel(1, 1, 0, 0, 0);
    setc(32'h3f);
    pixel(1, 1, 0, 1, 0);
    setc(32'h3e);
    pixel(1, 1, 0, 0, 0);
    pins_u.set_levels(1'b0, 1'b0);
    setc(32'h00);
    for (int i = 0; i < 3; i++) begin
      coef_m[i] = $random(seed) & 32'h01ff00ff;
      wr(ADDR_COEF_RED + 8'(4 * i), coef_m[i], r);
    end
    repeat (2) @(posedge aclk);
    check("red coef", red_c, coef_of(0));
    check("green coef", green_c, coef_of(1));
    check("blue coef", blue_c, coef_of(2));
    for (int s = 0; s < 4; s++) begin
      setc(32'h08 | s << 12);
      check("selected coef", red_c, coef_of(s % 3));
    end
    setc(32'h18);
    wr(ADDR_AUTO_CYCLE_ENABLE_RESET, 32'h0, r);
    repeat (2) @(posedge aclk);
    check("cycle reset", red_c, coef_of(0));
    q = {1, 2, 0, 1};
    while (q.size() > 0) begin
      pins_u.pulse_reset();
      repeat (3) @(posedge aclk);
      check("cycled coef", red_c, coef_of(q.pop_front()));
    end
    wr(ADDR_AUTO_CYCLE_ENABLE_RESET, 32'h7, r);
    repeat (2) @(posedge aclk);
    check("cycle reset", red_c, coef_of(0));
    end_of_test();
  end
endmodule
`default_nettype wire
